// file: bench/sleep_mode_strap_tb_top.sv
// self-checking bench for the strap configuration and mode control block
`timescale 1ns/1ps
module sleep_mode_strap_tb_top;
  `define CHK(a, e, m) begin n_compared++; \
    if ((a) !== (e)) begin n_mismatch++; $display("FAIL %0t %s", $time, m); end end
  localparam int HALF = 20;
  logic clock = 1'b0;
  logic rst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, supply = 1'b0, sw = 1'b0, run = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, q;
  logic ack, on_smp, on_run, sel_cur, gate, lowp, slp, above, below, hc, cond, da, db;
  logic [7:0] on_lvl, sel_lvl;
  logic [1:0] on_res = 2'h1, sel_res = 2'h0;
  logic [6:0] duty = 7'h32;
  int n_mismatch = 0, n_compared = 0;
  logic [6:0] t100 [4] = '{7'h50, 7'h4B, 7'h41, 7'h3C};
  logic [6:0] t180 [4] = '{7'h4B, 7'h46, 7'h3C, 7'h37};
  logic [6:0] tbm [4] = '{7'h50, 7'h4B, 7'h41, 7'h00};
  always #4 clock = ~clock;
  sleep_mode_strap sleep_mode_strap_inst (.CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SUPPLY_OK(supply), .ONOFF_ABOVE_ON(above), .ONOFF_BELOW_OFF(below), .ONOFF_LEVEL(on_lvl),
    .SELECT_LEVEL(sel_lvl), .HALF_CYCLE(hc), .CONDUCTING(cond), .DRAIN_A_ARMED(da), .DRAIN_B_ARMED(db),
    .ONOFF_SAMPLE_CURRENT(on_smp), .ONOFF_RUN_CURRENT(on_run), .SELECT_SAMPLE_CURRENT(sel_cur),
    .GATE_ENABLE(gate), .LOW_POWER(lowp), .SLEEP_ENABLED(slp));
  strap_partner #(.HALF(HALF)) strap_partner_inst (.clock(clock), .on_res(on_res), .sel_res(sel_res),
    .sw_closed(sw), .run(run), .duty(duty), .sel_cur(sel_cur), .on_lvl(on_lvl), .sel_lvl(sel_lvl),
    .above(above), .below(below), .hc(hc), .cond(cond), .drn_a(da), .drn_b(db));
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic fail(input string m);
    n_mismatch++;
    $display("FAIL %0t %s", $time, m);
    complete_run();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge clock);
    if (s !== v) fail("timeout");
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (int i = 0; i < 20; i++) begin
      @(posedge clock);
      if (ack === 1'b1) break;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) fail("no ack");
    @(posedge clock);
  endtask
  // remote off, release, then check the latched straps
  task automatic cfg(input logic [1:0] e, input logic [1:0] s);
    logic [31:0] exp_cfg;
    on_res <= e;
    sel_res <= s;
    sw <= 1'b1;
    idle(10);
    `CHK(lowp, 1'b1, "remote off power")
    `CHK(gate, 1'b0, "remote off gate")
    sw <= 1'b0;
    wait_for(on_smp, 1'b1, 20);
    `CHK(sel_cur, 1'b1, "select current")
    `CHK(on_run, 1'b0, "run current early")
    wait_for(on_smp, 1'b0, 1400);
    idle(2);
    `CHK(on_run, 1'b1, "run current")
    `CHK(sel_cur, 1'b0, "select off")
    `CHK(slp, e != 2'h3, "sleep flag")
    wb(1'b0, 4'h8, 32'h0000_0000);
    exp_cfg = {13'h0000, 1'b1, e, s, e == 2'h2 ? 7'h19 : 7'h28, e == 2'h2 ? t180[s] : t100[s]};
    if (e == 2'h3) `CHK(q & 32'h0007_C07F, {13'h0000, 1'b0, e, s, 7'h00, tbm[s]}, "config")
    else `CHK(q, exp_cfg, "config")
  endtask
  initial begin
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    `CHK(lowp, 1'b1, "reset power")
    `CHK(slp, 1'b0, "reset sleep")
    wb(1'b0, 4'h4, 32'h0000_0000);
    `CHK(q, 32'h0000_0081, "status off")
    supply <= 1'b1;
    wait_for(on_smp, 1'b1, 20);
    wait_for(gate, 1'b1, 1400);
    for (int e = 0; e < 4; e++) begin
      for (int s = 0; s < 4; s++) cfg(2'(e), 2'(s));
    end
    cfg(2'h2, 2'h0);
    wb(1'b0, 4'h4, 32'h0000_0000);
    `CHK(q, 32'h0000_0064, "status run")
    duty <= 7'h14;
    idle(500 * HALF);
    `CHK(lowp, 1'b0, "early sleep")
    wait_for(lowp, 1'b1, 40 * HALF);
    `CHK(gate, 1'b0, "gate in sleep")
    duty <= 7'h46;
    idle(40 * HALF);
    `CHK(lowp, 1'b1, "early exit")
    duty <= 7'h50;
    idle(23 * HALF);
    `CHK(gate, 1'b0, "early gate")
    wait_for(gate, 1'b1, 8 * HALF);
    wb(1'b0, 4'hC, 32'h0000_0000);
    `CHK(q, 32'h0000_0000, "unmapped read")
    wb(1'b1, 4'h0, 32'h0000_0001);
    wait_for(on_smp, 1'b1, 20);
    wait_for(on_smp, 1'b0, 1400);
    cfg(2'h3, 2'h1);
    duty <= 7'h14;
    idle(600 * HALF);
    `CHK(lowp, 1'b0, "duty sleep")
    run <= 1'b0;
    idle(2450);
    `CHK(lowp, 1'b0, "early pause")
    wait_for(lowp, 1'b1, 200);
    run <= 1'b1;
    duty <= 7'h46;
    idle(40 * HALF);
    `CHK(lowp, 1'b1, "burst exit early")
    duty <= 7'h50;
    wait_for(gate, 1'b1, 40 * HALF);
    wb(1'b1, 4'h0, 32'h0000_0002);
    `CHK(gate, 1'b0, "gate hold")
    wb(1'b0, 4'h0, 32'h0000_0000);
    `CHK(q, 32'h0000_0002, "ctrl read")
    wb(1'b1, 4'h0, 32'h0000_0000);
    `CHK(gate, 1'b1, "gate release")
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    `CHK(lowp, 1'b1, "mid-run reset power")
    `CHK(slp, 1'b0, "mid-run reset sleep")
    wb(1'b0, 4'h8, 32'h0000_0000);
    `CHK(q, 32'h0000_0000, "config cleared")
    complete_run();
  end
endmodule

// file: bench/strap_partner.sv
// far-side model: strap resistors, remote switch and primary half-bridge controller
`timescale 1ns/1ps
module strap_partner #(
  parameter int HALF = 20
) (
  input wire logic clock,
  input wire logic [1:0] on_res,
  input wire logic [1:0] sel_res,
  input wire logic sw_closed,
  input wire logic run,
  input wire logic [6:0] duty,
  input wire logic sel_cur,
  output logic [7:0] on_lvl,
  output logic [7:0] sel_lvl,
  output logic above,
  output logic below,
  output logic hc,
  output logic cond,
  output logic drn_a,
  output logic drn_b
);
  int cnt = 0;
  logic [7:0] flt = 8'h55;
  // strap voltage for each resistor option, open sits at the pull-up
  function automatic logic [7:0] lvl(input logic [1:0] c);
    return c == 2'h0 ? 8'h10 : c == 2'h1 ? 8'h40 : c == 2'h2 ? 8'h90 : 8'hE0;
  endfunction
  initial hc = 1'b0;
  always @(posedge clock) begin
    flt <= ~flt;
    if (!run) cnt <= 0;
    else if (cnt == HALF - 1) begin
      cnt <= 0;
      hc <= ~hc;
    end else cnt <= cnt + 1;
  end
  assign cond = run && (cnt * 100 < duty * HALF);
  // both drains sit above the arming voltage only while switching has stopped
  assign drn_a = !run || (!cond && !hc);
  assign drn_b = !run || (!cond && hc);
  assign above = !sw_closed;
  assign below = sw_closed;
  assign on_lvl = sw_closed ? 8'h00 : lvl(on_res);
  // unpowered select pin floats, shown as a toggling pattern
  assign sel_lvl = sel_cur ? lvl(sel_res) : flt;
endmodule

// file: pkg/strap_pkg.sv
// shared constants and types for the strap configuration and mode control block
package strap_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_SETTLE_NS = 10000;
  localparam int BURST_PAUSE_NS = 20000;
  localparam int SAMPLE_SETTLE_CYC = (SAMPLE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_PAUSE_CYC = (BURST_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CONFIRM_HC = 512;
  localparam int RESUME_WAIT_HC = 24;

  localparam logic [11:0] SETTLE_LAST = 12'(SAMPLE_SETTLE_CYC - 1);
  localparam logic [11:0] PAUSE_LAST = 12'(BURST_PAUSE_CYC - 1);
  localparam logic [9:0] SLEEP_LAST = 10'(SLEEP_CONFIRM_HC - 1);
  localparam logic [4:0] RESUME_LAST = 5'(RESUME_WAIT_HC - 1);

  // synchronised pin indices
  localparam int PIN_SUPPLY = 0;
  localparam int PIN_ABOVE = 1;
  localparam int PIN_BELOW = 2;
  localparam int PIN_HC = 3;
  localparam int PIN_COND = 4;
  localparam int PIN_DRAIN_A = 5;
  localparam int PIN_DRAIN_B = 6;
  localparam int NPINS = 7;

  // strap level quantiser bounds
  localparam logic [7:0] LVL_T1 = 8'h20;
  localparam logic [7:0] LVL_T2 = 8'h60;
  localparam logic [7:0] LVL_T3 = 8'hC0;

  localparam logic [1:0] RES_0R = 2'h0;
  localparam logic [1:0] RES_100K = 2'h1;
  localparam logic [1:0] RES_180K = 2'h2;
  localparam logic [1:0] RES_OPEN = 2'h3;

  localparam logic [6:0] DUTY_FULL = 7'h64;
  localparam logic [6:0] ENTRY_100K = 7'h28;
  localparam logic [6:0] ENTRY_180K = 7'h19;
  // index is the select strap code: 0R, 100k, 180k, open
  localparam logic [3:0][6:0] EXIT_100K_TBL = {7'h3C, 7'h41, 7'h4B, 7'h50};
  localparam logic [3:0][6:0] EXIT_180K_TBL = {7'h37, 7'h3C, 7'h46, 7'h4B};
  localparam logic [3:0][6:0] BURST_EXIT_TBL = {7'h00, 7'h41, 7'h4B, 7'h50};

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CONFIG = 4'h8;
  localparam int CTRL_RESAMPLE = 0;
  localparam int CTRL_GATE_HOLD = 1;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_SAMPLE = 5'b00010,
    ST_RUN = 5'b00100,
    ST_LOWPWR = 5'b01000,
    ST_RESUME = 5'b10000
  } mode_t;

  typedef struct packed {
    logic sleep_en;
    logic [1:0] en_code;
    logic [1:0] sel_code;
    logic [6:0] entry_duty;
    logic [6:0] exit_duty;
  } cfg_t;

  typedef struct packed {
    logic done;
    logic [15:0] period;
    logic [15:0] cond;
  } duty_t;

endpackage

// file: rtl/duty_meter.sv
// measures half-cycle length and conduction time in CLOCK cycles
`timescale 1ns/1ps
module duty_meter
  import strap_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic cond,
  output duty_t duty
);
  typedef struct packed {
    logic [15:0] per_cnt;
    logic [15:0] cond_cnt;
    duty_t out;
  } meter_state_t;

  meter_state_t q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.out.done = 1'b0;
    if (tick) begin
      q_nxt.out.done = 1'b1;
      q_nxt.out.period = q_r.per_cnt;
      q_nxt.out.cond = q_r.cond_cnt;
      q_nxt.per_cnt = 16'h0001;
      q_nxt.cond_cnt = {15'h0000, cond};
    end else begin
      // saturate so a stalled switching clock cannot wrap
      if (q_r.per_cnt != 16'hFFFF) begin
        q_nxt.per_cnt = q_r.per_cnt + 16'h0001;
      end
      if (cond && q_r.cond_cnt != 16'hFFFF) begin
        q_nxt.cond_cnt = q_r.cond_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign duty = q_r.out;
endmodule

// file: rtl/sleep_mode_strap.sv
// strap sampling, configuration latch and sleep / burst mode control with Wishbone access
`timescale 1ns/1ps
module sleep_mode_strap
  import strap_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SUPPLY_OK,
  input wire logic ONOFF_ABOVE_ON,
  input wire logic ONOFF_BELOW_OFF,
  input wire logic [7:0] ONOFF_LEVEL,
  input wire logic [7:0] SELECT_LEVEL,
  input wire logic HALF_CYCLE,
  input wire logic CONDUCTING,
  input wire logic DRAIN_A_ARMED,
  input wire logic DRAIN_B_ARMED,
  output logic ONOFF_SAMPLE_CURRENT,
  output logic ONOFF_RUN_CURRENT,
  output logic SELECT_SAMPLE_CURRENT,
  output logic GATE_ENABLE,
  output logic LOW_POWER,
  output logic SLEEP_ENABLED
);
  typedef struct packed {
    logic [NPINS-1:0] s1;
    logic [NPINS-1:0] s2;
    logic [NPINS-1:0] s3;
    logic [NPINS-1:0] pins;
    logic hc_prev;
    mode_t st;
    cfg_t cfg;
    logic [11:0] settle_cnt;
    logic [9:0] below_cnt;
    logic [11:0] pause_cnt;
    logic [4:0] resume_cnt;
    logic [11:0] smp_age;
    logic resample;
    logic gate_hold;
    logic ack;
    logic [31:0] dat;
    logic en_hi;
    logic en_run;
    logic sel_cur;
    logic gate;
    logic lowpwr;
  } top_state_t;

  top_state_t q_r, q_nxt;
  logic [1:0] en_code;
  logic [1:0] sel_code;
  duty_t dm;
  logic tick;
  logic [22:0] cond_x100;
  logic [22:0] per_x_entry;
  logic [22:0] per_x_exit;
  logic below_entry;
  logic above_exit;
  logic off_cond;
  logic bus_req;

  strap_quant u_onoff_quant (
    .clock(CLOCK),
    .rst(RST),
    .level(ONOFF_LEVEL),
    .code(en_code)
  );

  strap_quant u_select_quant (
    .clock(CLOCK),
    .rst(RST),
    .level(SELECT_LEVEL),
    .code(sel_code)
  );

  assign tick = q_r.pins[PIN_HC] ^ q_r.hc_prev;

  duty_meter u_duty (
    .clock(CLOCK),
    .rst(RST),
    .tick(tick),
    .cond(q_r.pins[PIN_COND]),
    .duty(dm)
  );

  // duty compared as cond*100 against period*threshold, so no divider is needed
  assign cond_x100 = {7'h00, dm.cond} * {16'h0000, DUTY_FULL};
  assign per_x_entry = {7'h00, dm.period} * {16'h0000, q_r.cfg.entry_duty};
  assign per_x_exit = {7'h00, dm.period} * {16'h0000, q_r.cfg.exit_duty};
  assign below_entry = cond_x100 < per_x_entry;
  assign above_exit = cond_x100 > per_x_exit;
  assign off_cond = !q_r.pins[PIN_SUPPLY] || q_r.pins[PIN_BELOW];
  assign bus_req = WB_CYC_I && WB_STB_I && !q_r.ack;

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = {DRAIN_B_ARMED, DRAIN_A_ARMED, CONDUCTING, HALF_CYCLE, ONOFF_BELOW_OFF, ONOFF_ABOVE_ON, SUPPLY_OK};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    for (int i = 0; i < NPINS; i++) begin
      if (q_r.s2[i] == q_r.s3[i]) begin
        q_nxt.pins[i] = q_r.s3[i];
      end
    end
    q_nxt.hc_prev = q_r.pins[PIN_HC];
    // cycles spent in the sampling phase, watched by the sampling-time check
    q_nxt.smp_age = (q_r.st == ST_SAMPLE) ? q_r.smp_age + 12'h001 : 12'h000;

    unique case (q_r.st)
      ST_OFF: begin
        if (q_r.pins[PIN_SUPPLY] && q_r.pins[PIN_ABOVE]) begin
          q_nxt.st = ST_SAMPLE;
          q_nxt.settle_cnt = 12'h000;
        end
      end
      ST_SAMPLE: begin
        q_nxt.settle_cnt = q_r.settle_cnt + 12'h001;
        if (q_r.settle_cnt == SETTLE_LAST) begin
          q_nxt.st = ST_RUN;
          q_nxt.cfg.en_code = en_code;
          q_nxt.cfg.sel_code = sel_code;
          q_nxt.cfg.sleep_en = (en_code != RES_OPEN);
          q_nxt.cfg.entry_duty = (en_code == RES_180K) ? ENTRY_180K : ENTRY_100K;
          if (en_code == RES_OPEN) begin
            q_nxt.cfg.exit_duty = BURST_EXIT_TBL[sel_code];
          end else if (en_code == RES_180K) begin
            q_nxt.cfg.exit_duty = EXIT_180K_TBL[sel_code];
          end else begin
            q_nxt.cfg.exit_duty = EXIT_100K_TBL[sel_code];
          end
        end
      end
      ST_RUN: begin
        if (dm.done) begin
          if (q_r.cfg.sleep_en && below_entry) begin
            q_nxt.below_cnt = q_r.below_cnt + 10'h001;
            if (q_r.below_cnt == SLEEP_LAST) begin
              q_nxt.st = ST_LOWPWR;
            end
          end else begin
            q_nxt.below_cnt = 10'h000;
          end
        end
        if (q_r.pins[PIN_DRAIN_A] && q_r.pins[PIN_DRAIN_B]) begin
          q_nxt.pause_cnt = q_r.pause_cnt + 12'h001;
          if (q_r.pause_cnt == PAUSE_LAST) begin
            q_nxt.st = ST_LOWPWR;
          end
        end else begin
          q_nxt.pause_cnt = 12'h000;
        end
      end
      ST_LOWPWR: begin
        if (dm.done && above_exit) begin
          q_nxt.st = ST_RESUME;
          q_nxt.resume_cnt = 5'h00;
        end
      end
      ST_RESUME: begin
        if (dm.done) begin
          q_nxt.resume_cnt = q_r.resume_cnt + 5'h01;
          if (q_r.resume_cnt == RESUME_LAST) begin
            q_nxt.st = ST_RUN;
          end
        end
      end
    endcase

    if (q_nxt.st != ST_RUN) begin
      q_nxt.below_cnt = 10'h000;
      q_nxt.pause_cnt = 12'h000;
    end
    // software resample is taken once the block is configured
    if (q_r.resample && q_r.st != ST_OFF && q_r.st != ST_SAMPLE) begin
      q_nxt.resample = 1'b0;
      q_nxt.st = ST_SAMPLE;
      q_nxt.settle_cnt = 12'h000;
    end
    if (off_cond) begin
      q_nxt.st = ST_OFF;
    end

    // one-cycle ack: a held strobe is not taken again while ack stands
    q_nxt.ack = bus_req;
    if (bus_req) begin
      unique case (WB_ADR_I)
        REG_CTRL: q_nxt.dat = {30'h0000_0000, q_r.gate_hold, q_r.resample};
        REG_STATUS: q_nxt.dat = {24'h00_0000, q_r.lowpwr, q_r.gate, q_r.cfg.sleep_en, q_r.st};
        REG_CONFIG: q_nxt.dat = {13'h0000, q_r.cfg};
        default: q_nxt.dat = 32'h0000_0000;
      endcase
      if (WB_WE_I && WB_SEL_I[0] && WB_ADR_I == REG_CTRL) begin
        q_nxt.gate_hold = WB_DAT_I[CTRL_GATE_HOLD];
        if (WB_DAT_I[CTRL_RESAMPLE]) begin
          q_nxt.resample = 1'b1;
        end
      end
    end

    q_nxt.en_hi = (q_nxt.st == ST_SAMPLE);
    q_nxt.en_run = (q_nxt.st != ST_SAMPLE) && (q_nxt.st != ST_OFF);
    q_nxt.sel_cur = (q_nxt.st == ST_SAMPLE);
    q_nxt.gate = (q_nxt.st == ST_RUN) && !q_nxt.gate_hold;
    q_nxt.lowpwr = (q_nxt.st == ST_OFF) || (q_nxt.st == ST_LOWPWR) || (q_nxt.st == ST_RESUME);
  end

  // reset clears the latched straps and leaves the block in low power
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      q_r <= '0;
      q_r.st <= ST_OFF;
      q_r.lowpwr <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign WB_DAT_O = q_r.dat;
  assign WB_ACK_O = q_r.ack;
  assign ONOFF_SAMPLE_CURRENT = q_r.en_hi;
  assign ONOFF_RUN_CURRENT = q_r.en_run;
  assign SELECT_SAMPLE_CURRENT = q_r.sel_cur;
  assign GATE_ENABLE = q_r.gate;
  assign LOW_POWER = q_r.lowpwr;
  assign SLEEP_ENABLED = q_r.cfg.sleep_en;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  AST_CFG_HOLD: assert property ((q_r.st == ST_RUN) && ($past(q_r.st) == ST_RUN) |-> $stable(q_r.cfg))
    else $error("configuration changed while running");
  AST_SAMPLE_ENDS: assert property ((q_r.st == ST_SAMPLE) |-> (q_r.smp_age <= SETTLE_LAST))
    else $error("sampling phase did not end");
  AST_REMOTE_OFF: assert property (q_r.pins[PIN_BELOW] |=> (q_r.st == ST_OFF) && q_r.lowpwr && !q_r.gate)
    else $error("remote off not obeyed");
  AST_RESAMPLE: assert property ((q_r.st == ST_OFF) && q_r.pins[PIN_ABOVE] && !off_cond |=> q_r.st == ST_SAMPLE)
    else $error("on-off rise did not start sampling");
  AST_SLEEP_EN: assert property ($rose(q_r.st == ST_RUN) && ($past(q_r.st) == ST_SAMPLE)
    |-> q_r.cfg.sleep_en == ($past(en_code) != RES_OPEN))
    else $error("sleep enable latched wrong");
  AST_OPEN_DISABLES: assert property ($rose(q_r.st == ST_RUN) && ($past(en_code) == RES_OPEN)
    && ($past(q_r.st) == ST_SAMPLE) |-> !SLEEP_ENABLED)
    else $error("open on-off pin left sleep enabled");
  AST_ONOFF_CURRENT: assert property ($fell(q_r.st == ST_SAMPLE) |-> !ONOFF_SAMPLE_CURRENT
    && (ONOFF_RUN_CURRENT || q_r.st == ST_OFF))
    else $error("on-off current not lowered");
  AST_SELECT_CURRENT: assert property ((q_r.st != ST_SAMPLE) |-> !SELECT_SAMPLE_CURRENT)
    else $error("select current left on");
  AST_ENTRY_DUTY: assert property ($rose(q_r.st == ST_RUN) && ($past(q_r.st) == ST_SAMPLE)
    |-> q_r.cfg.entry_duty == (($past(en_code) == RES_180K) ? ENTRY_180K : ENTRY_100K))
    else $error("wrong sleep entry duty");
  AST_EXIT_DUTY: assert property ($rose(q_r.st == ST_RUN) && ($past(q_r.st) == ST_SAMPLE)
    && ($past(en_code) == RES_180K) |-> q_r.cfg.exit_duty == EXIT_180K_TBL[$past(sel_code)])
    else $error("wrong sleep exit duty");
  AST_BURST_EXIT: assert property ($rose(q_r.st == ST_RUN) && ($past(q_r.st) == ST_SAMPLE)
    && !q_r.cfg.sleep_en |-> q_r.cfg.exit_duty == BURST_EXIT_TBL[$past(sel_code)])
    else $error("wrong burst exit duty");
  AST_SLEEP_CAUSE: assert property ($rose(q_r.st == ST_LOWPWR) && !$past(off_cond)
    |-> ($past(q_r.cfg.sleep_en) && $past(q_r.below_cnt) == SLEEP_LAST) || $past(q_r.pause_cnt) == PAUSE_LAST)
    else $error("low power entered without cause");
  AST_DISABLED_NO_SLEEP: assert property ((q_r.st == ST_RUN) && !q_r.cfg.sleep_en
    |-> q_r.below_cnt == 10'h000)
    else $error("duty sleep counting while disabled");
  AST_PAUSE: assert property ((q_r.st == ST_RUN) && (q_r.pause_cnt == PAUSE_LAST) && q_r.pins[PIN_DRAIN_A]
    && q_r.pins[PIN_DRAIN_B] && !off_cond && !q_r.resample |=> q_r.st == ST_LOWPWR)
    else $error("burst pause not recognised");
  AST_RESUME_WAIT: assert property ($rose(q_r.st == ST_RUN) && ($past(q_r.st) == ST_RESUME)
    |-> $past(q_r.resume_cnt) == RESUME_LAST)
    else $error("gate restarted early");
  AST_GATE_ONLY_RUN: assert property (GATE_ENABLE |-> (q_r.st == ST_RUN) && !q_r.gate_hold)
    else $error("gate enabled outside run");
  AST_LOWPWR_NO_GATE: assert property (LOW_POWER |-> !GATE_ENABLE)
    else $error("gate enabled in low power");

  COV_CONFIGURED: cover property ($past(q_r.st) == ST_SAMPLE && q_r.st == ST_RUN);
  COV_SLEEP: cover property ($past(q_r.st) == ST_RUN && q_r.st == ST_LOWPWR);
  COV_WAKE: cover property ($past(q_r.st) == ST_RESUME && q_r.st == ST_RUN);
  COV_BURST_SLEEP: cover property ($past(q_r.st) == ST_RUN && q_r.st == ST_LOWPWR && !q_r.cfg.sleep_en);
endmodule

// file: rtl/strap_quant.sv
// synchronises one strap level word and quantises it into a resistor code
`timescale 1ns/1ps
module strap_quant
  import strap_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] level,
  output logic [1:0] code
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] held;
    logic [1:0] code;
  } quant_state_t;

  quant_state_t q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = level;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    // a word counts only once two stages agree
    if (q_r.s2 == q_r.s3) begin
      q_nxt.held = q_r.s3;
    end
    if (q_r.held < LVL_T1) begin
      q_nxt.code = RES_0R;
    end else if (q_r.held < LVL_T2) begin
      q_nxt.code = RES_100K;
    end else if (q_r.held < LVL_T3) begin
      q_nxt.code = RES_180K;
    end else begin
      q_nxt.code = RES_OPEN;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign code = q_r.code;
endmodule
